// File: bl_fade_regs.vh
// constants for the backlight fade register bank
//
// Behaviour
// - reg 0x00: rate 7:6, fade 5, code 4:0
// - rate 00/01/10/11 gives 32/24/16/8 ms
// - step count equals code difference
// - fade moves applied code one per interval
// - code writes ignored while fading
// - clearing fade enable applies target at once
// - fade off: new code applies immediately
// - rate rewrite affects remaining fade steps
// - reset rate selects 32 ms interval
// - code maps to shared sink current
// - reg 0x01: four sink enables, reset clear
// - sink conducts only when enabled
// - reg 0x03: reg b 6:4, reg a 3:0
// - reg b code: off, 1.8 to 1.5 V
// - reg a code: off, 3.3 to 2.5 V
// - chip enable low holds registers at defaults
// - all sinks off enters sleep
`ifndef BL_FADE_REGS_VH
`define BL_FADE_REGS_VH

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define REG_CUR_OFS   8'h00
`define REG_SINK_OFS  8'h01
`define REG_VOLT_OFS  8'h03
`define REG_CUR_RST   8'h00
`define REG_SINK_RST  4'h0
`define REG_VOLT_RST  7'h00
`define RATE_RST      2'h0
`define CODE_RST      5'h00

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define RATE_HI   7
`define RATE_LO   6
`define FADE_BIT  5
`define CODE_HI   4
`define CODE_LO   0
`define SINK_HI   3
`define REGB_HI   6
`define REGB_LO   4
`define REGA_HI   3

// -----------------------------------------------------------------
// serial port and timing
// -----------------------------------------------------------------
`define SLAVE_ADDR    7'h37
`define BIT_LAST      4'h8
`define TX_LAST       4'h7
`define FADE_UNIT_MS  8
`define CLK_KHZ       50000
`define UNITS_SLOW    3'h4

// -----------------------------------------------------------------
// current and voltage decode
// -----------------------------------------------------------------
`define CODE_KNEE_A   5'h17
`define CODE_KNEE_B   5'h1a
`define HALF_OFS_B    7'h16
`define HALF_OFS_C    7'h4a
`define REGA_MAX      4'h9
`define REGA_BASE     6'h22
`define REGB_MAX      3'h4
`define REGB_BASE     5'h13

`endif

// File: backlight_fade_register_bank.v
// backlight fade register bank with sampled two-wire slave port
`timescale 1ns/1ps
`default_nettype none
`include "bl_fade_regs.vh"

module backlight_fade_register_bank #(
  parameter                 CYC_W            = 20,
  parameter [CYC_W-1:0]     FADE_UNIT_CYCLES = `FADE_UNIT_MS * `CLK_KHZ
) (
  // clock and reset
  input  wire               clk,
  input  wire               rst,
  // chip enable pin
  input  wire               chip_en,
  // two-wire serial pins
  input  wire               scl_in,
  input  wire               sda_in,
  output wire               sda_out,
  output wire               sda_oe_n,
  // sink control
  output wire [4:0]         sink_current_code,
  output wire [6:0]         sink_current_half_ma,
  output wire [3:0]         sink_on_bits,
  output wire               fade_busy,
  output wire               sleep_active,
  // regulator control
  output wire [3:0]         reg_a_voltage_code,
  output wire [2:0]         reg_b_voltage_code,
  output wire               reg_a_on,
  output wire [5:0]         reg_a_decivolts,
  output wire               reg_b_on,
  output wire [4:0]         reg_b_decivolts
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  reg  [2:0] en_sync_q;
  reg  [2:0] scl_sync_q;
  reg  [2:0] sda_sync_q;

  // stage 0 is read only by stage 1; stage 2 is the previous sample
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_sync_q  <= 3'h0;
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      en_sync_q  <= {en_sync_q[1:0], chip_en};
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  wire en_s     = en_sync_q[1];
  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_sync_q[2];
  wire scl_fall = ~scl_s & scl_sync_q[2];
  wire start_c  = scl_s & scl_sync_q[2] & ~sda_s & sda_sync_q[2];
  wire stop_c   = scl_s & scl_sync_q[2] & sda_s & ~sda_sync_q[2];

  // -----------------------------------------------------------------
  // serial slave engine
  // -----------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_ACK  = 6'h04;
  localparam [5:0] ST_RXB  = 6'h08;
  localparam [5:0] ST_TX   = 6'h10;
  localparam [5:0] ST_MACK = 6'h20;

  reg  [5:0] st_q;
  reg  [3:0] bit_q;
  reg  [7:0] sh_q;
  reg  [7:0] tx_q;
  reg  [7:0] ptr_q;
  reg        rw_q;
  reg        data_ph_q;
  reg        drive_q;
  reg        wr_q;
  reg  [7:0] wdat_q;
  wire [7:0] rdat;

  // byte engine: start and stop override every state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q      <= ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      data_ph_q <= 1'b0;
      drive_q   <= 1'b0;
      wr_q      <= 1'b0;
      wdat_q    <= 8'h00;
    end else if (!en_s) begin
      st_q      <= ST_IDLE;
      bit_q     <= 4'h0;
      ptr_q     <= 8'h00;
      drive_q   <= 1'b0;
      wr_q      <= 1'b0;
      data_ph_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (start_c) begin
        st_q    <= ST_ADDR;
        bit_q   <= 4'h0;
        drive_q <= 1'b0;
      end else if (stop_c) begin
        st_q    <= ST_IDLE;
        drive_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            drive_q <= 1'b0;
          end
          ST_ADDR, ST_RXB: begin
            if (scl_rise && bit_q != `BIT_LAST) begin
              sh_q  <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == `BIT_LAST) begin
              bit_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                if (sh_q[7:1] == `SLAVE_ADDR) begin
                  rw_q      <= sh_q[0];
                  data_ph_q <= 1'b0;
                  st_q      <= ST_ACK;
                  drive_q   <= 1'b1;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                // first byte after address is the pointer, the rest are data
                if (!data_ph_q) begin
                  ptr_q     <= sh_q;
                  data_ph_q <= 1'b1;
                end else begin
                  wr_q   <= 1'b1;
                  wdat_q <= sh_q;
                end
                st_q    <= ST_ACK;
                drive_q <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_q <= 4'h0;
              if (rw_q) begin
                st_q    <= ST_TX;
                tx_q    <= rdat;
                drive_q <= ~rdat[7];
              end else begin
                st_q    <= ST_RXB;
                drive_q <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_q == `TX_LAST) begin
                st_q    <= ST_MACK;
                drive_q <= 1'b0;
              end else begin
                tx_q    <= {tx_q[6:0], 1'b0};
                drive_q <= ~tx_q[6];
                bit_q   <= bit_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            // no auto increment: an acked read repeats the same register
            if (scl_rise && sda_s) begin
              st_q <= ST_IDLE;
            end else if (scl_fall) begin
              st_q    <= ST_TX;
              bit_q   <= 4'h0;
              tx_q    <= rdat;
              drive_q <= ~rdat[7];
            end
          end
          default: begin
            st_q    <= ST_IDLE;
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_q;

  // -----------------------------------------------------------------
  // registers and fade engine
  // -----------------------------------------------------------------
  localparam [CYC_W-1:0] UNIT_LAST = FADE_UNIT_CYCLES - {{(CYC_W-1){1'b0}}, 1'b1};

  reg  [1:0]       rate_q;
  reg              fade_en_q;
  reg  [4:0]       target_q;
  reg  [4:0]       applied_q;
  reg  [3:0]       sink_q;
  reg  [6:0]       volt_q;
  reg  [CYC_W-1:0] cyc_q;
  reg  [2:0]       unit_q;

  wire       fading      = fade_en_q & (applied_q != target_q);
  wire [2:0] units_need  = `UNITS_SLOW - {1'b0, rate_q};
  wire       wr_cur      = wr_q & (ptr_q == `REG_CUR_OFS);
  wire       wr_sink     = wr_q & (ptr_q == `REG_SINK_OFS);
  wire       wr_volt     = wr_q & (ptr_q == `REG_VOLT_OFS);
  wire       sleep_w     = (sink_q == `REG_SINK_RST);

  // chip enable low clears everything, same as reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_q    <= `RATE_RST;
      fade_en_q <= 1'b0;
      target_q  <= `CODE_RST;
      applied_q <= `CODE_RST;
      sink_q    <= `REG_SINK_RST;
      volt_q    <= `REG_VOLT_RST;
      cyc_q     <= {CYC_W{1'b0}};
      unit_q    <= 3'h0;
    end else if (!en_s) begin
      rate_q    <= `RATE_RST;
      fade_en_q <= 1'b0;
      target_q  <= `CODE_RST;
      applied_q <= `CODE_RST;
      sink_q    <= `REG_SINK_RST;
      volt_q    <= `REG_VOLT_RST;
      cyc_q     <= {CYC_W{1'b0}};
      unit_q    <= 3'h0;
    end else begin
      if (wr_sink) begin
        sink_q <= wdat_q[`SINK_HI:0];
      end
      if (wr_volt) begin
        volt_q <= wdat_q[`REGB_HI:0];
      end
      if (wr_cur) begin
        rate_q    <= wdat_q[`RATE_HI:`RATE_LO];
        fade_en_q <= wdat_q[`FADE_BIT];
        if (!fading) begin
          target_q <= wdat_q[`CODE_HI:`CODE_LO];
          cyc_q    <= {CYC_W{1'b0}};
          unit_q   <= 3'h0;
        end
        // the code field of a write landing mid-fade is dropped
        if (!wdat_q[`FADE_BIT]) begin
          applied_q <= fading ? target_q : wdat_q[`CODE_HI:`CODE_LO];
        end
      end else if (fading && !sleep_w) begin
        // fade stepping is gated off in sleep, so the interval count holds
        if (cyc_q == UNIT_LAST) begin
          cyc_q <= {CYC_W{1'b0}};
          if (unit_q + 3'h1 >= units_need) begin
            unit_q <= 3'h0;
            if (applied_q < target_q) begin
              applied_q <= applied_q + 5'h01;
            end else begin
              applied_q <= applied_q - 5'h01;
            end
          end else begin
            unit_q <= unit_q + 3'h1;
          end
        end else begin
          cyc_q <= cyc_q + {{(CYC_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // read mux, unmapped pointers read zero
  assign rdat = (ptr_q == `REG_CUR_OFS)  ? {rate_q, fade_en_q, target_q} :
                (ptr_q == `REG_SINK_OFS) ? {4'h0, sink_q} :
                (ptr_q == `REG_VOLT_OFS) ? {1'b0, volt_q} : 8'h00;

  // -----------------------------------------------------------------
  // output decode
  // -----------------------------------------------------------------
  wire [6:0] code7 = {2'b00, applied_q};
  wire [3:0] ra    = volt_q[`REGA_HI:0];
  wire [2:0] rb    = volt_q[`REGB_HI:`REGB_LO];

  // half-milliamp units: fine steps low, coarse steps high
  assign sink_current_half_ma = (applied_q <= `CODE_KNEE_A) ? code7 + 7'h01 :
                                (applied_q <= `CODE_KNEE_B) ? {code7[5:0], 1'b0} - `HALF_OFS_B :
                                {code7[4:0], 2'b00} - `HALF_OFS_C;

  assign sink_current_code  = applied_q;
  assign sink_on_bits       = sink_q;
  assign fade_busy          = fading;
  assign sleep_active       = sleep_w;
  assign reg_a_voltage_code = ra;
  assign reg_b_voltage_code = rb;
  assign reg_a_on           = (ra != 4'h0) && (ra <= `REGA_MAX);
  assign reg_a_decivolts    = reg_a_on ? `REGA_BASE - {2'b00, ra} : 6'h00;
  assign reg_b_on           = (rb != 3'h0) && (rb <= `REGB_MAX);
  assign reg_b_decivolts    = reg_b_on ? `REGB_BASE - {2'b00, rb} : 5'h00;

endmodule // backlight_fade_register_bank

`default_nettype wire

// File: backlight_fade_register_bank_chk.sv
// port checker for the backlight fade register bank
`timescale 1ns/1ps
`default_nettype none
module bl_fade_chk #(
  parameter int FADE_UNIT_CYCLES = 20
) (
  // clock, reset, chip enable, serial driver
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       chip_en,
  input wire logic       sda_oe_n,
  // sink side
  input wire logic [4:0] sink_current_code,
  input wire logic [6:0] sink_current_half_ma,
  input wire logic [3:0] sink_on_bits,
  input wire logic       fade_busy,
  input wire logic       sleep_active,
  // regulator side
  input wire logic [3:0] reg_a_voltage_code,
  input wire logic [2:0] reg_b_voltage_code,
  input wire logic       reg_a_on,
  input wire logic [5:0] reg_a_decivolts,
  input wire logic       reg_b_on,
  input wire logic [4:0] reg_b_decivolts
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] code_q;
  int         gap_q;
  // cycles since the applied code last moved; cleared outside a live fade
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      code_q <= 5'h00;
      gap_q  <= 0;
    end else begin
      code_q <= sink_current_code;
      gap_q  <= (!fade_busy || sleep_active || sink_current_code != code_q) ? 0 : gap_q + 1;
    end
  end
  property p_sleep;
    sleep_active == (sink_on_bits == 4'h0);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flag disagrees with sink enables");
  property p_half;
    sink_current_half_ma == ((sink_current_code <= 5'h17) ? {2'h0, sink_current_code} + 7'h01 :
      (sink_current_code <= 5'h1a) ? {1'b0, sink_current_code, 1'b0} - 7'h16 : {sink_current_code, 2'h0} - 7'h4a);
  endproperty
  a_half: assert property (p_half)
    else $error("sink current figure wrong for code");
  property p_reg_a;
    reg_a_on == (reg_a_voltage_code inside {[4'h1:4'h9]}) &&
      reg_a_decivolts == (reg_a_on ? 6'h22 - {2'h0, reg_a_voltage_code} : 6'h00);
  endproperty
  a_reg_a: assert property (p_reg_a)
    else $error("regulator a decode wrong");
  property p_reg_b;
    reg_b_on == (reg_b_voltage_code inside {[3'h1:3'h4]}) &&
      reg_b_decivolts == (reg_b_on ? 5'h13 - {2'h0, reg_b_voltage_code} : 5'h00);
  endproperty
  a_reg_b: assert property (p_reg_b)
    else $error("regulator b decode wrong");
  property p_step;
    $past(fade_busy) && fade_busy && sink_current_code != code_q |->
      sink_current_code == code_q + 5'h01 || code_q == sink_current_code + 5'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("fade moved by more than one count");
  property p_gap_min;
    fade_busy && sink_current_code != code_q |-> gap_q >= FADE_UNIT_CYCLES - 2;
  endproperty
  a_gap_min: assert property (p_gap_min)
    else $error("fade step came too early");
  property p_gap_max;
    fade_busy && !sleep_active |-> gap_q <= 4 * FADE_UNIT_CYCLES + 4;
  endproperty
  a_gap_max: assert property (p_gap_max)
    else $error("fade step overdue");
  property p_rst;
    disable iff (1'b0) rst |-> sda_oe_n && sink_on_bits == 4'h0 && !fade_busy && sink_current_code == 5'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared in reset");
  property p_chip_off;
    !chip_en [*3] |=> sink_on_bits == 4'h0 && sink_current_code == 5'h00 && reg_a_voltage_code == 4'h0 &&
      reg_b_voltage_code == 3'h0;
  endproperty
  a_chip_off: assert property (p_chip_off)
    else $error("registers kept while chip disabled");
endmodule // bl_fade_chk
bind backlight_fade_register_bank bl_fade_chk #(.FADE_UNIT_CYCLES(FADE_UNIT_CYCLES)) bl_fade_chk_inst (
  .clk, .rst, .chip_en, .sda_oe_n, .sink_current_code, .sink_current_half_ma, .sink_on_bits, .fade_busy,
  .sleep_active, .reg_a_voltage_code, .reg_b_voltage_code, .reg_a_on, .reg_a_decivolts, .reg_b_on, .reg_b_decivolts);
`default_nettype wire

// File: bl_host_model.sv
// two-wire bus master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module bl_host_model (
  // pacing clock and resolved data line
  input  wire logic clk,
  input  wire logic sda_line,
  // master pins, high means released to the pull-up
  output var logic  scl,
  output var logic  sda
);
  int half = 4;  // clk cycles per half bit; 4 gives 80 ns, larger is a slow host
  // clock idles high outside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // one half bit of waiting
  task automatic tick();
    repeat (half) @(posedge clk);
  endtask
  // start or repeated start; extra wait lets the slave let go of an ack first
  task automatic start();
    sda <= 1'b1;
    tick();
    tick();
    scl <= 1'b1;
    tick();
    sda <= 1'b0;
    tick();
    scl <= 1'b0;
  endtask
  // data moves one clk after scl falls, sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk) sda <= b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda_line;
    scl <= 1'b0;
  endtask
  // stop condition
  task automatic stop();
    @(posedge clk) sda <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda <= 1'b1;
    tick();
  endtask
endmodule // bl_host_model
`default_nettype wire

// File: backlight_fade_register_bank_tb.sv
// self-checking bench for the backlight fade register bank
`timescale 1ns/1ps
`default_nettype none
module backlight_fade_register_bank_tb;
  localparam int U = 20;  // short fade unit keeps the run brief
  logic       clk, rst, chip_en;
  wire        scl, host_sda, sda_out, sda_oe_n, fade_busy, sleep_active, reg_a_on, reg_b_on;
  wire  [4:0] sink_current_code, reg_b_decivolts;
  wire  [6:0] sink_current_half_ma;
  wire  [3:0] sink_on_bits, reg_a_voltage_code;
  wire  [2:0] reg_b_voltage_code;
  wire  [5:0] reg_a_decivolts;
  wire        sda_line = host_sda & (sda_oe_n | sda_out);  // pull-up wins when nobody pulls
  int         errors, check_count, busy_cnt, b0, seed;
  backlight_fade_register_bank #(.FADE_UNIT_CYCLES(20'd20)) backlight_fade_register_bank_inst (
    .clk, .rst, .chip_en, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n, .sink_current_code,
    .sink_current_half_ma, .sink_on_bits, .fade_busy, .sleep_active, .reg_a_voltage_code,
    .reg_b_voltage_code, .reg_a_on, .reg_a_decivolts, .reg_b_on, .reg_b_decivolts);
  bl_host_model bl_host_model_inst (.clk, .sda_line, .scl, .sda(host_sda));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic int fade_len(int n, int r);
    return n * (4 - r) * U;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // byte then ninth bit; ea is the level the ninth bit should show
  task automatic send(input logic [7:0] d, input logic ea, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bl_host_model_inst.bit_x(d[i], q[i]);
    bl_host_model_inst.bit_x(1'b1, a);
    chk("ack", {7'h00, ea}, {7'h00, a});
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    bl_host_model_inst.start();
    send(8'h6e, 1'b0, q);
    send(p, 1'b0, q);
    send(d, 1'b0, q);
    bl_host_model_inst.stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    bl_host_model_inst.start();
    send(8'h6e, 1'b0, q);
    send(p, 1'b0, q);
    bl_host_model_inst.start();
    send(8'h6f, 1'b0, q);
    send(8'hff, 1'b1, q);
    bl_host_model_inst.stop();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 2000 && fade_busy !== 1'b0; i++) @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // busy time summed over the whole run, never cleared
  always @(posedge clk) if (fade_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // watchdog well past the expected run
  initial begin
    #1500000;
    errors++;
    final_report();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] q, d;
    logic [4:0] t;
    int         k;
    seed = 32'h48fa9b00;
    rst = 1'b1;
    chip_en = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 4; a++) begin
      rd(a[7:0], q);
      chk("reset_value", 8'h00, q);
    end
    // foreign address must not be acknowledged
    bl_host_model_inst.start();
    send(8'h50, 1'b1, q);
    bl_host_model_inst.stop();
    for (int i = 0; i < 6; i++) begin
      bl_host_model_inst.half = (i % 2) ? 7 : 4;
      // all-ones word first, then top reg a and off-range reg b codes, then random
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h59 : 8'($random(seed));
      wr(8'h01, d & 8'h0f);
      wr(8'h03, d & 8'h7f);
      wr(8'h02, d);
      wr(8'h00, {3'h0, d[4:0]});
      chk("code", {3'h0, d[4:0]}, {3'h0, sink_current_code});
      chk("sink_on_bits", d & 8'h0f, {4'h0, sink_on_bits});
      rd(8'h01, q);
      chk("sink_en", d & 8'h0f, q);
      rd(8'h03, q);
      chk("volt", d & 8'h7f, q);
      rd(8'h02, q);
      chk("unmapped", 8'h00, q);
      rd(8'h00, q);
      chk("current_reg", {3'h0, d[4:0]}, q);
    end
    bl_host_model_inst.half = 4;
    wr(8'h01, 8'h0f);
    // every rate, random distance, alternating direction
    for (int r = 0; r < 4; r++) begin
      k = ($random(seed) & 3) + 1;
      t = r[0] ? 5'(10 - k) : 5'(10 + k);
      wr(8'h00, {r[1:0], 6'h0a});
      b0 = busy_cnt;
      wr(8'h00, {r[1:0], 1'b1, t});
      wait_idle();
      chk("fade_end", {3'h0, t}, {3'h0, sink_current_code});
      chk("fade_time", 8'h01, {7'h00, busy_cnt - b0 >= fade_len(k, r) - 2 && busy_cnt - b0 <= fade_len(k, r) + 6});
    end
    // code rewrite ignored, rate rewrite taken
    wr(8'h00, 8'h00);
    b0 = busy_cnt;
    wr(8'h00, 8'h34);
    wr(8'h00, 8'hff);
    wait_idle();
    chk("fade_target", 8'h14, {3'h0, sink_current_code});
    chk("rate_switch", 8'h01, {7'h00, busy_cnt - b0 < fade_len(20, 0)});
    // abort lands on the stored target
    wr(8'h00, 8'h20);
    wr(8'h00, 8'h07);
    chk("abort", 8'h00, {3'h0, sink_current_code});
    // sinks off freeze the fade; abort still lands on the stored target
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h25);
    repeat (200) @(posedge clk);
    chk("sleep_hold", 8'h00, {3'h0, sink_current_code});
    chk("sleep_busy", 8'h01, {7'h00, fade_busy});
    wr(8'h00, 8'h03);
    chk("sleep_abort", 8'h05, {3'h0, sink_current_code});
    wr(8'h01, 8'h0a);
    chip_en <= 1'b0;
    repeat (5) @(posedge clk);
    chip_en <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h01, q);
    chk("chip_off", 8'h00, q);
    final_report();
  end
endmodule // backlight_fade_register_bank_tb
`default_nettype wire
